// *** design/dsg_defs.svh ***
// offsets, field positions, reset values and masks of the gate/reset block
`ifndef DSG_DEFS_SVH
`define DSG_DEFS_SVH

`define DSG_ADDR_W 12
`define DSG_PORTS 8

`define DSG_OFF_SOFT_RST 12'h040
`define DSG_OFF_RUN_CFG 12'h060
`define DSG_OFF_RUN_GATE 12'h108
`define DSG_OFF_SLEEP_GATE 12'h118
`define DSG_OFF_DEEP_GATE 12'h128
`define DSG_OFF_IRQ_STAT 12'h150
`define DSG_OFF_IRQ_MASK 12'h154
`define DSG_OFF_FAULT_INFO 12'h158
`define DSG_OFF_GATE_STAT 12'h15c

`define DSG_BIT_PWM_RST 20
`define DSG_BIT_HIBERN_RST 6
`define DSG_BIT_WATCHDOG_RST 3
`define DSG_SOFT_RST_IMPL 32'h00100048

`define DSG_BIT_AUTO_GATE 27

`define DSG_IRQ_W 2
`define DSG_IRQ_FAULT 0
`define DSG_IRQ_PMCHG 1

`define DSG_RST_GATE 8'h00
`define DSG_RST_SOFT_RST 32'h00000000
`define DSG_RST_IRQ 2'h0

`endif

// *** design/dsg_gate_cell.sv ***
// per-port selection of the gating bit that applies in the current power mode
`timescale 1ns/1ps
`default_nettype none

module dsg_gate_cell
	import dsg_pkg::*;
(
	input wire logic run_bit,
	input wire logic sleep_bit,
	input wire logic deep_bit,
	input wire dsg_pm_t pm,
	input wire logic auto_gate,
	output logic clk_on
);

	// without auto gating the run register governs every mode
	always_comb begin
		clk_on = run_bit;
		if (auto_gate) begin
			case (pm)
			DSG_PM_RUN: clk_on = run_bit;
			DSG_PM_SLEEP: clk_on = sleep_bit;
			DSG_PM_DEEP: clk_on = deep_bit;
			default: clk_on = run_bit;
			endcase
		end
	end

endmodule

`default_nettype wire

// *** design/dsg_pkg.sv ***
// types shared by the deep-sleep gate and soft reset block
`include "dsg_defs.svh"

package dsg_pkg;

	typedef enum logic [1:0] {
		DSG_PM_RUN,
		DSG_PM_SLEEP,
		DSG_PM_DEEP
	} dsg_pm_t;

	typedef struct packed {
		logic [`DSG_ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dsg_bus_req_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] port;
	} dsg_acc_req_t;

	typedef struct packed {
		logic done;
		logic fault;
	} dsg_acc_rsp_t;

	typedef struct packed {
		logic pwm;
		logic hibern;
		logic watchdog;
	} dsg_unit_rst_t;

	typedef struct packed {
		logic [`DSG_PORTS-1:0] run_gate;
		logic [`DSG_PORTS-1:0] sleep_gate;
		logic [`DSG_PORTS-1:0] deep_gate;
		logic auto_gate;
		logic [31:0] soft_rst;
		logic [`DSG_IRQ_W-1:0] irq_stat;
		logic [`DSG_IRQ_W-1:0] irq_mask;
		logic irq;
		logic [2:0] fault_port;
		logic fault_write;
		logic [7:0] fault_cnt;
		dsg_pm_t pm;
		logic [`DSG_PORTS-1:0] clk_en;
		dsg_unit_rst_t unit_rst;
		dsg_acc_rsp_t rsp;
		logic [31:0] rdata;
	} dsg_state_t;

endpackage

// *** design/dsg_top.sv ***
// deep-sleep port clock gating and peripheral soft reset control
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module dsg_top
	import dsg_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire dsg_bus_req_t bus_req,
	output logic [31:0] bus_rdata,
	input wire logic [31:0] capability_mask_1,
	input wire dsg_pm_t power_mode,
	input wire dsg_acc_req_t acc_req,
	output dsg_acc_rsp_t acc_rsp,
	output logic [`DSG_PORTS-1:0] port_clk_en,
	output dsg_unit_rst_t unit_rst,
	output logic irq
);

	localparam dsg_state_t DSG_STATE_RST = '{
		run_gate: `DSG_RST_GATE,
		sleep_gate: `DSG_RST_GATE,
		deep_gate: `DSG_RST_GATE,
		auto_gate: 1'b0,
		soft_rst: `DSG_RST_SOFT_RST,
		irq_stat: `DSG_RST_IRQ,
		irq_mask: `DSG_RST_IRQ,
		irq: 1'b0,
		fault_port: 3'h0,
		fault_write: 1'b0,
		fault_cnt: 8'h00,
		pm: DSG_PM_RUN,
		clk_en: `DSG_RST_GATE,
		unit_rst: 3'h0,
		rsp: 2'h0,
		rdata: 32'h00000000
	};

	dsg_state_t s_q;
	dsg_state_t s_d;

	logic [`DSG_PORTS-1:0] gate_sel;
	logic wr_soft_rst;
	logic wr_run_cfg;
	logic wr_run_gate;
	logic wr_sleep_gate;
	logic wr_deep_gate;
	logic wr_irq_stat;
	logic wr_irq_mask;
	logic [31:0] srst_mask;
	logic [`DSG_IRQ_W-1:0] irq_set;
	logic [`DSG_IRQ_W-1:0] irq_clr;
	logic acc_fault;

	// one selector per port, all fed from the current mode
	genvar gi;
	generate
		for (gi = 0; gi < `DSG_PORTS; gi = gi + 1) begin : g_port
			dsg_gate_cell u_cell (
				.run_bit(s_q.run_gate[gi]),
				.sleep_bit(s_q.sleep_gate[gi]),
				.deep_bit(s_q.deep_gate[gi]),
				.pm(power_mode),
				.auto_gate(s_q.auto_gate),
				.clk_on(gate_sel[gi])
			);
		end
	endgenerate

	// write address decode
	always_comb begin
		wr_soft_rst = bus_req.wr && (bus_req.addr == `DSG_OFF_SOFT_RST);
		wr_run_cfg = bus_req.wr && (bus_req.addr == `DSG_OFF_RUN_CFG);
		wr_run_gate = bus_req.wr && (bus_req.addr == `DSG_OFF_RUN_GATE);
		wr_sleep_gate = bus_req.wr && (bus_req.addr == `DSG_OFF_SLEEP_GATE);
		wr_deep_gate = bus_req.wr && (bus_req.addr == `DSG_OFF_DEEP_GATE);
		wr_irq_stat = bus_req.wr && (bus_req.addr == `DSG_OFF_IRQ_STAT);
		wr_irq_mask = bus_req.wr && (bus_req.addr == `DSG_OFF_IRQ_MASK);
	end

	// only present, implemented units may be changed by software
	assign srst_mask = capability_mask_1 & `DSG_SOFT_RST_IMPL;

	// the fault check uses the clock actually delivered, not the
	// register contents, so a mode change takes effect one cycle later
	assign acc_fault = acc_req.valid && !s_q.clk_en[acc_req.port];

	// interrupt events: faulted access and power mode change
	always_comb begin
		irq_set = '0;
		irq_set[`DSG_IRQ_FAULT] = acc_fault;
		irq_set[`DSG_IRQ_PMCHG] = (power_mode != s_q.pm);
		irq_clr = '0;
		if (wr_irq_stat) begin
			irq_clr = bus_req.wdata[`DSG_IRQ_W-1:0];
		end
	end

	// next state
	always_comb begin
		s_d = s_q;
		s_d.rsp = 2'h0;
		s_d.rdata = 32'h00000000;
		s_d.pm = power_mode;

		// gating registers keep only the eight port bits
		if (wr_run_gate) begin
			s_d.run_gate = bus_req.wdata[`DSG_PORTS-1:0];
		end
		if (wr_sleep_gate) begin
			s_d.sleep_gate = bus_req.wdata[`DSG_PORTS-1:0];
		end
		if (wr_deep_gate) begin
			s_d.deep_gate = bus_req.wdata[`DSG_PORTS-1:0];
		end
		if (wr_run_cfg) begin
			s_d.auto_gate = bus_req.wdata[`DSG_BIT_AUTO_GATE];
		end

		// masked merge keeps bits of absent units unchanged
		if (wr_soft_rst) begin
			s_d.soft_rst = (s_q.soft_rst & ~srst_mask) |
				(bus_req.wdata & srst_mask);
		end

		if (wr_irq_mask) begin
			s_d.irq_mask = bus_req.wdata[`DSG_IRQ_W-1:0];
		end
		// a new event beats a clear in the same cycle
		s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

		// access answer one cycle after the request
		if (acc_req.valid) begin
			s_d.rsp.done = !acc_fault;
			s_d.rsp.fault = acc_fault;
		end
		if (acc_fault) begin
			s_d.fault_port = acc_req.port;
			s_d.fault_write = acc_req.write;
			if (s_q.fault_cnt != 8'hff) begin
				s_d.fault_cnt = s_q.fault_cnt + 8'h01;
			end
		end

		// delivered clocks follow the selected register
		s_d.clk_en = gate_sel;

		// units held in reset for as long as their bit is set
		s_d.unit_rst.pwm = s_d.soft_rst[`DSG_BIT_PWM_RST];
		s_d.unit_rst.hibern = s_d.soft_rst[`DSG_BIT_HIBERN_RST];
		s_d.unit_rst.watchdog = s_d.soft_rst[`DSG_BIT_WATCHDOG_RST];

		// read mux, unmapped addresses read zero
		if (bus_req.rd) begin
			case (bus_req.addr)
			`DSG_OFF_SOFT_RST: begin
				s_d.rdata = s_q.soft_rst & `DSG_SOFT_RST_IMPL;
			end
			`DSG_OFF_RUN_CFG: begin
				s_d.rdata[`DSG_BIT_AUTO_GATE] = s_q.auto_gate;
			end
			`DSG_OFF_RUN_GATE: begin
				s_d.rdata[`DSG_PORTS-1:0] = s_q.run_gate;
			end
			`DSG_OFF_SLEEP_GATE: begin
				s_d.rdata[`DSG_PORTS-1:0] = s_q.sleep_gate;
			end
			`DSG_OFF_DEEP_GATE: begin
				s_d.rdata[`DSG_PORTS-1:0] = s_q.deep_gate;
			end
			`DSG_OFF_IRQ_STAT: begin
				s_d.rdata[`DSG_IRQ_W-1:0] = s_q.irq_stat;
			end
			`DSG_OFF_IRQ_MASK: begin
				s_d.rdata[`DSG_IRQ_W-1:0] = s_q.irq_mask;
			end
			`DSG_OFF_FAULT_INFO: begin
				s_d.rdata[15:8] = s_q.fault_cnt;
				s_d.rdata[4] = s_q.fault_write;
				s_d.rdata[2:0] = s_q.fault_port;
			end
			`DSG_OFF_GATE_STAT: begin
				s_d.rdata[`DSG_PORTS-1:0] = s_q.clk_en;
			end
			default: begin
				s_d.rdata = 32'h00000000;
			end
			endcase
		end
	end

	// whole block state in one register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= DSG_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus_rdata = s_q.rdata;
	assign acc_rsp = s_q.rsp;
	assign port_clk_en = s_q.clk_en;
	assign unit_rst = s_q.unit_rst;
	assign irq = s_q.irq;

endmodule

`default_nettype wire

// *** sim/dsg_props.sv ***
// port checks of the gate and soft reset block
`timescale 1ns/1ps
`default_nettype none
`include "dsg_defs.svh"
module dsg_props
	import dsg_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire dsg_bus_req_t bus_req,
	input wire logic [31:0] bus_rdata,
	input wire logic [31:0] capability_mask_1,
	input wire dsg_pm_t power_mode,
	input wire dsg_acc_req_t acc_req,
	input wire dsg_acc_rsp_t acc_rsp,
	input wire logic [`DSG_PORTS-1:0] port_clk_en,
	input wire dsg_unit_rst_t unit_rst,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic sw;
	logic [31:0] d;
	logic [31:0] m;
	// soft reset write strobe and its masked bits
	assign sw = bus_req.wr && bus_req.addr == `DSG_OFF_SOFT_RST;
	assign d = bus_req.wdata;
	assign m = capability_mask_1;
	a_dog_set: assert property (
		sw && d[3] && m[3] |=> unit_rst.watchdog)
		else $error("watchdog not held");
	a_dog_clr: assert property (
		sw && !d[3] && m[3] |=> !unit_rst.watchdog)
		else $error("watchdog held");
	a_hibern_set: assert property (
		sw && d[6] && m[6] |=> unit_rst.hibern)
		else $error("hibernation not held");
	a_pwm_set: assert property (
		sw && d[20] && m[20] |=> unit_rst.pwm) else $error("pwm not held");
	a_mask_keep: assert property (
		sw && !m[20] |=> $stable(unit_rst.pwm)) else $error("mask ignored");
	a_acc_fault: assert property (
		acc_req.valid && !port_clk_en[acc_req.port] |=> acc_rsp == 2'b01)
		else $error("no fault");
	a_acc_done: assert property (
		acc_req.valid && port_clk_en[acc_req.port] |=> acc_rsp == 2'b10)
		else $error("no done");
	a_gate_resv: assert property (
		bus_req.rd && bus_req.addr == `DSG_OFF_DEEP_GATE
		|=> bus_rdata[31:8] == 24'h000000) else $error("gate reserved");
	a_srst_resv: assert property (
		bus_req.rd && sw == 1'b0 && bus_req.addr == `DSG_OFF_SOFT_RST
		|=> (bus_rdata & ~`DSG_SOFT_RST_IMPL) == 32'h0)
		else $error("reset reserved");
	c_fault: cover property (acc_rsp.fault);
	c_done: cover property (acc_rsp.done);
	c_dog: cover property (unit_rst.watchdog);
	c_irq: cover property (irq);
endmodule
`default_nettype wire

// *** sim/dsg_top_bench.sv ***
// self-checking bench of the gate and soft reset block
`timescale 1ns/1ps
`default_nettype none
`include "dsg_defs.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
miscompares++; $display("unexpected %s exp %h got %h", n, e, s); end end
module dsg_top_bench
	import dsg_pkg::*;
;
	logic clk;
	logic nrst;
	dsg_bus_req_t req;
	logic [31:0] rdata;
	logic [31:0] cap;
	logic [31:0] v;
	dsg_pm_t pm;
	dsg_acc_req_t acc;
	dsg_acc_rsp_t rsp;
	logic [7:0] en;
	logic [7:0] pt;
	logic [7:0] wt;
	logic [7:0] t;
	dsg_unit_rst_t ur;
	logic irq;
	int miscompares;
	int checks_done;
	dsg_top dut (.clk(clk), .nrst(nrst), .bus_req(req), .bus_rdata(rdata),
		.capability_mask_1(cap), .power_mode(pm), .acc_req(acc),
		.acc_rsp(rsp), .port_clk_en(en), .unit_rst(ur), .irq(irq));
	dsg_unit_model units (.clk(clk), .nrst(nrst), .port_clk_en(en),
		.unit_rst(ur), .port_ticks(pt), .dog_ticks(wt));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input logic [11:0] a);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1 v = rdata;
	endtask
	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task acc_t(input logic [2:0] p, input logic f);
		@(posedge clk);
		acc.valid <= 1'b1;
		acc.port <= p;
		@(posedge clk);
		acc.valid <= 1'b0;
		#1 `CHK("acc_rsp", {~f, f}, rsp)
	endtask
	task t_reset;
		rd(`DSG_OFF_DEEP_GATE);
		`CHK("deep_gate", 32'h0, v)
		rd(`DSG_OFF_SOFT_RST);
		`CHK("soft_rst", 32'h0, v)
		`CHK("clk_en", 8'h00, en)
		rd(12'hff0);
		`CHK("unmapped", 32'h0, v)
	endtask
	task t_soft;
		int b[3];
		b = '{20, 6, 3};
		@(posedge clk) cap <= 32'hffffffff;
		for (int i = 0; i < 3; i++) begin
			wr(`DSG_OFF_SOFT_RST, 32'h1 << b[i]);
			`CHK("unit_rst", 3'b100 >> i, ur)
		end
		wr(`DSG_OFF_SOFT_RST, 32'hffffffff);
		rd(`DSG_OFF_SOFT_RST);
		`CHK("soft_rst", `DSG_SOFT_RST_IMPL, v)
		`CHK("dog_ticks", 8'h00, wt)
		wr(`DSG_OFF_SOFT_RST, 32'h0);
		repeat (4) @(posedge clk);
		#1;
		`CHK("dog_runs", 1'b1, wt != 8'h00)
		@(posedge clk) cap <= 32'h0;
		wr(`DSG_OFF_SOFT_RST, 32'hffffffff);
		rd(`DSG_OFF_SOFT_RST);
		`CHK("masked", 32'h0, v)
	endtask
	// reserved bits dropped; deep mode ignored until auto gating set
	task t_gate;
		wr(`DSG_OFF_DEEP_GATE, 32'hffffff5a);
		rd(`DSG_OFF_DEEP_GATE);
		`CHK("deep_gate", 32'h5a, v)
		wr(`DSG_OFF_RUN_GATE, 32'h0f);
		@(posedge clk) pm <= DSG_PM_DEEP;
		settle;
		`CHK("clk_en", 8'h0f, en)
		wr(`DSG_OFF_RUN_CFG, 32'h1 << `DSG_BIT_AUTO_GATE);
		settle;
		`CHK("clk_en", 8'h5a, en)
		t = pt;
		repeat (4) @(posedge clk);
		#1;
		`CHK("port_ticks", t, pt)
		wr(`DSG_OFF_SLEEP_GATE, 32'h33);
		@(posedge clk) pm <= DSG_PM_SLEEP;
		settle;
		`CHK("clk_en", 8'h33, en)
		// port a is clocked in sleep, so its unit advances every cycle
		t = pt;
		repeat (4) @(posedge clk);
		#1;
		`CHK("port_ticks", t + 8'h04, pt)
		@(posedge clk) pm <= DSG_PM_DEEP;
		settle;
	endtask
	task t_fault;
		wr(`DSG_OFF_IRQ_STAT, 32'h3);
		wr(`DSG_OFF_IRQ_MASK, 32'h1);
		acc_t(3'd0, 1'b1);
		`CHK("irq", 1'b1, irq)
		rd(`DSG_OFF_FAULT_INFO);
		`CHK("fault_info", 32'h00000100, v)
		acc_t(3'd1, 1'b0);
		wr(`DSG_OFF_IRQ_MASK, 32'h0);
		settle;
		`CHK("irq_masked", 1'b0, irq)
		wr(`DSG_OFF_IRQ_STAT, 32'h3);
		wr(`DSG_OFF_IRQ_MASK, 32'h1);
		settle;
		`CHK("irq_clear", 1'b0, irq)
		// a power mode change is an interrupt event of its own
		wr(`DSG_OFF_IRQ_MASK, 32'h2);
		@(posedge clk) pm <= DSG_PM_RUN;
		settle;
		`CHK("irq_pm", 1'b1, irq)
		rd(`DSG_OFF_IRQ_STAT);
		`CHK("irq_stat", 32'h2, v)
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// whole run needs under a hundred cycles
	initial begin
		#20000;
		miscompares++;
		end_of_test;
	end
	initial begin
		nrst = 1'b0;
		req = '0;
		cap = 32'h0;
		pm = DSG_PM_RUN;
		acc = '0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_reset;
		t_soft;
		t_gate;
		t_fault;
		end_of_test;
	end
endmodule
bind dsg_top dsg_props props (.clk(clk), .nrst(nrst), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .capability_mask_1(capability_mask_1),
	.power_mode(power_mode), .acc_req(acc_req), .acc_rsp(acc_rsp),
	.port_clk_en(port_clk_en), .unit_rst(unit_rst), .irq(irq));
`default_nettype wire

// *** sim/dsg_unit_model.sv ***
// gated port A unit and watchdog unit seen from outside
`timescale 1ns/1ps
`default_nettype none
module dsg_unit_model
	import dsg_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] port_clk_en,
	input wire dsg_unit_rst_t unit_rst,
	output logic [7:0] port_ticks,
	output logic [7:0] dog_ticks
);
	// port A unit only advances when its clock is enabled, watchdog unit only when out of soft reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port_ticks <= 8'h00;
			dog_ticks <= 8'h00;
		end else begin
			if (port_clk_en[0])
				port_ticks <= port_ticks + 8'h01;
			dog_ticks <= unit_rst.watchdog ? 8'h00 : dog_ticks + 8'h01;
		end
	end
endmodule
`default_nettype wire
